// ==== core/wbc_cs_sync.sv ====
// two-stage synchroniser for chip select with release detect
`timescale 1ns/100ps
`default_nettype none

module wbc_cs_sync
(
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic async_in,
   output logic      sync_out,
   output logic      rise_out
);

   logic meta_r;
   logic sync_r;
   logic last_r;

   // ------------------------------------------------------------------
   // synchroniser chain, idle level high
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         last_r <= 1'b1;
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   // release edge seen only after the second stage
   assign sync_out = sync_r;
   assign rise_out = sync_r & ~last_r;

endmodule : wbc_cs_sync

`default_nettype wire

// ==== core/wbc_regs.sv ====
// watchdog, bus transceiver and supply peak control register bank
//
// Function
// [R1] host writes watchdog control with even parity over all eight bits
// [R2] bit 6 of watchdog control deactivates the watchdog in stop mode
// [R3] bit 5 selects time-out watchdog at zero, window watchdog at one
// [R4] bit 4 starts watchdog with long open window after bus wake
// [R5] period codes give 10 to 1000 ms; all-ones code reserved
// [R6] reserved bits always read zero
// [R7] watchdog control resets to 14h; restart sets 0100, clears bit 6
// [R8] lin flash bit 7 disables slope control for high baud rates
// [R9] lin bit 6 selects low-slope mode
// [R10] lin bit 5 enables the transmit time-out protection
// [R11] lin option writes take effect when chip select goes high
// [R12] lin one mode field bits 4:3, hardware may update it
// [R13] can mode field bits 1:0, hardware may update it
// [R14] fail-safe entry forces bus control xxx0 1001, wake x0x0 0111
// [R15] bus control resets to 20h; restart modes by cause, bit 2 zero
// [R16] peak bit 5 picks low threshold at zero, higher at one
// [R17] peak bit writable in init and normal mode only
// [R18] ignored peak write in stop raises no spi failure
// [R19] peak register resets to zero; restart keeps only bit 5
// [R20] registers decoded at addresses 03h, 04h and 05h
// [R21] second stop-mode watchdog disable bit sits in internal wake bit 2
// [R22] global interrupt bit 7 of external wake control
// [R23] restart bits marked x keep their value, digits are loaded
`timescale 1ns/100ps
`default_nettype none

module wbc_regs
(
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       chip_select_low_in,
   input  wire logic       reg_wr_in,
   input  wire logic [6:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic       soft_reset_in,
   input  wire logic       restart_in,
   input  wire logic [1:0] restart_lin_mode_in,
   input  wire logic [1:0] restart_can_mode_in,
   input  wire logic       fail_safe_entry_in,
   input  wire logic       stop_mode_in,
   input  wire logic       hw_lin_mode_we_in,
   input  wire logic [1:0] hw_lin_mode_in,
   input  wire logic       hw_can_mode_we_in,
   input  wire logic [1:0] hw_can_mode_in,
   output logic            spi_fail_out,
   output logic            stop_dog_disable_lo_out,
   output logic            stop_dog_disable_hi_out,
   output logic            dog_type_select_out,
   output logic            dog_start_on_bus_wake_out,
   output logic      [2:0] dog_period_select_out,
   output logic      [9:0] dog_period_ms_out,
   output logic            lin_flash_out,
   output logic            lin_low_slope_out,
   output logic            lin_transmit_timeout_en_out,
   output logic      [1:0] lin_one_mode_out,
   output logic      [1:0] can_mode_out,
   output logic            active_peak_threshold_out,
   output logic            global_int_en_out
);

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [7:0] dog_ctrl_r;
   logic [7:0] bus_ctrl_r;
   logic [7:0] peak_ctrl_r;
   logic [7:0] int_wake_r;
   logic [7:0] ext_wake_r;
   logic [2:0] lin_opt_r;
   logic [7:0] rdata_r;
   logic [9:0] period_ms_r;
   logic       spi_fail_r;
   logic       cs_rise;
   logic       init_any;
   logic       wr_dog;
   logic       wr_bus;
   logic       wr_peak;
   logic       wr_iwk;
   logic       wr_ewk;
   logic       dog_parity_ok;

   // ------------------------------------------------------------------
   // chip select synchroniser
   // ------------------------------------------------------------------
   wbc_cs_sync u_cs_sync
   (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .async_in (chip_select_low_in),
      .sync_out (),
      .rise_out (cs_rise)
   );

   // ------------------------------------------------------------------
   // address decode and write qualification
   // ------------------------------------------------------------------
   // power-on and soft reset load the same values
   assign init_any = soft_reset_in;

   // register selects
   assign wr_dog  = reg_wr_in & (reg_addr_in ==
                    wbc_pkg::ADDR_WATCHDOG_CONTROL); // [R20]
   assign wr_bus  = reg_wr_in & (reg_addr_in ==
                    wbc_pkg::ADDR_BUS_TRANSCEIVER); // [R20]
   assign wr_peak = reg_wr_in & (reg_addr_in ==
                    wbc_pkg::ADDR_SUPPLY_PEAK); // [R20]
   assign wr_iwk  = reg_wr_in & (reg_addr_in ==
                    wbc_pkg::ADDR_INT_WAKE_CONTROL);
   assign wr_ewk  = reg_wr_in & (reg_addr_in ==
                    wbc_pkg::ADDR_EXT_WAKE_CONTROL);

   // even parity over all eight written bits, checksum bit included
   assign dog_parity_ok = ~(^reg_wdata_in); // [R1]

   // ------------------------------------------------------------------
   // watchdog control register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || init_any)
      begin
         dog_ctrl_r <= wbc_pkg::WD_RESET_VAL; // [R7]
      end
      else if (restart_in)
      begin
         // checksum, type and bus wake bits survive a restart
         dog_ctrl_r <= (dog_ctrl_r & wbc_pkg::WD_RESTART_KEEP) |
                       wbc_pkg::WD_RESTART_VAL; // [R7] [R23]
      end
      else if (wr_dog && dog_parity_ok)
      begin
         dog_ctrl_r <= reg_wdata_in & wbc_pkg::WD_RW_MASK; // [R6]
      end
   end

   // ------------------------------------------------------------------
   // bus transceiver control register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || init_any)
      begin
         bus_ctrl_r <= wbc_pkg::BUS_RESET_VAL; // [R15]
      end
      else if (restart_in)
      begin
         // lin options kept, modes set by the restart cause
         bus_ctrl_r <= (bus_ctrl_r & wbc_pkg::BUS_RESTART_KEEP) |
                       {3'h0, restart_lin_mode_in, 1'b0,
                        restart_can_mode_in}; // [R15] [R23]
      end
      else if (fail_safe_entry_in)
      begin
         // wake capable modes keep the chip wakeable
         bus_ctrl_r <= (bus_ctrl_r & wbc_pkg::BUS_FAIL_KEEP) |
                       wbc_pkg::BUS_FAIL_VAL; // [R14]
      end
      else if (hw_lin_mode_we_in || hw_can_mode_we_in)
      begin
         // hardware mode changes win over a write in the same cycle
         if (hw_lin_mode_we_in)
         begin
            bus_ctrl_r[wbc_pkg::BUS_LIN_MSB:wbc_pkg::BUS_LIN_LSB] <=
               hw_lin_mode_in; // [R12]
         end
         if (hw_can_mode_we_in)
         begin
            bus_ctrl_r[wbc_pkg::BUS_CAN_MSB:wbc_pkg::BUS_CAN_LSB] <=
               hw_can_mode_in; // [R13]
         end
      end
      else if (wr_bus)
      begin
         bus_ctrl_r <= reg_wdata_in & wbc_pkg::BUS_RW_MASK; // [R6]
      end
   end

   // ------------------------------------------------------------------
   // lin options applied to the lin outputs at chip select release, restart or fail-safe entry
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || init_any)
      begin
         lin_opt_r <= wbc_pkg::BUS_RESET_VAL[7:5];
      end
      else if (restart_in || fail_safe_entry_in)
      begin
         lin_opt_r <= bus_ctrl_r[7:5];
      end
      else if (cs_rise)
      begin
         lin_opt_r <= bus_ctrl_r[7:5]; // [R11]
      end
   end

   // ------------------------------------------------------------------
   // supply peak control register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || init_any)
      begin
         peak_ctrl_r <= wbc_pkg::PEAK_RESET_VAL; // [R19]
      end
      else if (restart_in)
      begin
         peak_ctrl_r <= peak_ctrl_r & wbc_pkg::PEAK_RESTART_KEEP; // [R19]
      end
      else if (wr_peak && !stop_mode_in)
      begin
         // writes in stop mode are dropped silently
         peak_ctrl_r <= reg_wdata_in & wbc_pkg::PEAK_RW_MASK; // [R17]
      end
   end

   // ------------------------------------------------------------------
   // internal wake control register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || init_any)
      begin
         int_wake_r <= wbc_pkg::IWK_RESET_VAL;
      end
      else if (restart_in)
      begin
         int_wake_r <= int_wake_r & wbc_pkg::IWK_RESTART_KEEP; // [R23]
      end
      else if (wr_iwk)
      begin
         int_wake_r <= reg_wdata_in & wbc_pkg::IWK_RW_MASK; // [R21]
      end
   end

   // ------------------------------------------------------------------
   // external wake control register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in || init_any)
      begin
         ext_wake_r <= wbc_pkg::EWK_RESET_VAL;
      end
      else if (restart_in)
      begin
         ext_wake_r <= ext_wake_r & wbc_pkg::EWK_RESTART_KEEP; // [R23]
      end
      else if (fail_safe_entry_in)
      begin
         ext_wake_r <= (ext_wake_r & wbc_pkg::EWK_FAIL_KEEP) |
                       wbc_pkg::EWK_FAIL_VAL; // [R14]
      end
      else if (wr_ewk)
      begin
         ext_wake_r <= reg_wdata_in & wbc_pkg::EWK_RW_MASK; // [R22]
      end
   end

   // ------------------------------------------------------------------
   // read back, one cycle latency, unmapped reads zero
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         rdata_r <= 8'h00;
      end
      else
      begin
         case (reg_addr_in)
            wbc_pkg::ADDR_WATCHDOG_CONTROL: rdata_r <= dog_ctrl_r;
            wbc_pkg::ADDR_BUS_TRANSCEIVER:  rdata_r <= bus_ctrl_r;
            wbc_pkg::ADDR_SUPPLY_PEAK:      rdata_r <= peak_ctrl_r;
            wbc_pkg::ADDR_INT_WAKE_CONTROL: rdata_r <= int_wake_r;
            wbc_pkg::ADDR_EXT_WAKE_CONTROL: rdata_r <= ext_wake_r;
            default:                        rdata_r <= 8'h00; // [R6]
         endcase
      end
   end

   // ------------------------------------------------------------------
   // watchdog period decode in ms
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         period_ms_r <= wbc_pkg::PERIOD_MS_4;
      end
      else
      begin
         case (dog_ctrl_r[wbc_pkg::WD_PERIOD_MSB:0]) // [R5]
            3'h0:    period_ms_r <= wbc_pkg::PERIOD_MS_0;
            3'h1:    period_ms_r <= wbc_pkg::PERIOD_MS_1;
            3'h2:    period_ms_r <= wbc_pkg::PERIOD_MS_2;
            3'h3:    period_ms_r <= wbc_pkg::PERIOD_MS_3;
            3'h4:    period_ms_r <= wbc_pkg::PERIOD_MS_4;
            3'h5:    period_ms_r <= wbc_pkg::PERIOD_MS_5;
            default: period_ms_r <= wbc_pkg::PERIOD_MS_6; // reserved too
         endcase
      end
   end

   // ------------------------------------------------------------------
   // spi failure: only a watchdog write with bad parity
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         spi_fail_r <= 1'b0;
      end
      else
      begin
         // a dropped peak write in stop mode is deliberately not counted
         spi_fail_r <= wr_dog & ~dog_parity_ok & ~init_any &
                       ~restart_in; // [R18]
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign reg_rdata_out  = rdata_r;
   assign spi_fail_out   = spi_fail_r;
   assign stop_dog_disable_lo_out =
      dog_ctrl_r[wbc_pkg::WD_STOP_DISABLE_BIT]; // [R2]
   assign stop_dog_disable_hi_out =
      int_wake_r[wbc_pkg::IWK_STOP_DISABLE_BIT]; // [R21]
   assign dog_type_select_out = dog_ctrl_r[wbc_pkg::WD_TYPE_BIT]; // [R3]
   assign dog_start_on_bus_wake_out =
      dog_ctrl_r[wbc_pkg::WD_BUS_WAKE_BIT]; // [R4]
   assign dog_period_select_out =
      dog_ctrl_r[wbc_pkg::WD_PERIOD_MSB:0]; // [R5]
   assign dog_period_ms_out = period_ms_r;
   // applied lin options, not the raw register
   assign lin_flash_out = lin_opt_r[2]; // [R8]
   assign lin_low_slope_out = lin_opt_r[1]; // [R9]
   assign lin_transmit_timeout_en_out = lin_opt_r[0]; // [R10]
   assign lin_one_mode_out =
      bus_ctrl_r[wbc_pkg::BUS_LIN_MSB:wbc_pkg::BUS_LIN_LSB]; // [R12]
   assign can_mode_out =
      bus_ctrl_r[wbc_pkg::BUS_CAN_MSB:wbc_pkg::BUS_CAN_LSB]; // [R13]
   assign active_peak_threshold_out =
      peak_ctrl_r[wbc_pkg::PEAK_BIT]; // [R16]
   assign global_int_en_out =
      ext_wake_r[wbc_pkg::EWK_GLOBAL_INT_BIT]; // [R22]

endmodule : wbc_regs

`default_nettype wire

// ==== dv/wbc_host.sv ====
// spi master stand-in driving the register strobe side
`timescale 1ns/100ps
`default_nettype none
module wbc_host
(
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output logic            cs_b_out,
   output logic            wr_out,
   output logic      [6:0] addr_out,
   output logic      [7:0] wdata_out
);
   // idle host: deselected, no strobe
   initial
   begin
      cs_b_out = 1'b1;
      wr_out = 1'b0;
      addr_out = 7'h00;
      wdata_out = 8'h00;
   end
   // one write; the checksum bit is spoiled only when bad is set
   task automatic write(input logic [6:0] a, input logic [7:0] d,
                        input logic bad);
      @(negedge clk_in);
      cs_b_out = 1'b0;
      wr_out = 1'b1;
      addr_out = a;
      wdata_out = (a == 7'h03) ? {^d[6:0] ^ bad, d[6:0]} : d;
      @(negedge clk_in);
      wr_out = 1'b0;
      wdata_out = ~wdata_out; // released data lines do not hold
   endtask : write
   // present an address, then take the registered answer
   task automatic read(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      @(negedge clk_in);
      d = rdata_in;
   endtask : read
   // release chip select to close the frame
   task automatic frame_end();
      @(negedge clk_in);
      cs_b_out = 1'b1;
   endtask : frame_end
endmodule : wbc_host
`default_nettype wire

// ==== dv/wbc_regs_bench.sv ====
// self-checking bench for the control register bank
`timescale 1ns/100ps
`default_nettype none
module wbc_regs_bench;
   logic        clk_in, rst_b_in, cs_b, wr, soft_rst, restart, fail_safe;
   logic        stop, hl_we, hc_we, spi_fail, hi, gi;
   logic  [1:0] rs_lin, rs_can, hl, hc;
   logic  [6:0] addr, a;
   logic  [7:0] wdata, rdata, e3, e4, e5, got;
   logic  [9:0] ms;
   logic [31:0] seed, r;
   wire   [2:0] opts;
   int          err_total, checks, fails, cyc;
   wbc_regs dut_u
   (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .chip_select_low_in(cs_b),
      .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .soft_reset_in(soft_rst), .restart_in(restart),
      .restart_lin_mode_in(rs_lin), .restart_can_mode_in(rs_can),
      .fail_safe_entry_in(fail_safe), .stop_mode_in(stop),
      .hw_lin_mode_we_in(hl_we), .hw_lin_mode_in(hl),
      .hw_can_mode_we_in(hc_we), .hw_can_mode_in(hc), .spi_fail_out(spi_fail),
      .stop_dog_disable_lo_out(), .stop_dog_disable_hi_out(hi),
      .dog_type_select_out(), .dog_start_on_bus_wake_out(),
      .dog_period_select_out(), .dog_period_ms_out(ms),
      .lin_flash_out(opts[2]), .lin_low_slope_out(opts[1]),
      .lin_transmit_timeout_en_out(opts[0]), .lin_one_mode_out(),
      .can_mode_out(), .active_peak_threshold_out(), .global_int_en_out(gi)
   );
   wbc_host host_u
   (
      .clk_in(clk_in), .rdata_in(rdata), .cs_b_out(cs_b), .wr_out(wr),
      .addr_out(addr), .wdata_out(wdata)
   );
   // free-running clock
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // hang guard and failure pulse count
   always @(posedge clk_in)
   begin
      cyc++;
      fails += (spi_fail === 1'b1);
      if (cyc == 3000)
      begin
         err_total++;
         $display("ERROR %0t: timeout", $time);
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask : tick
   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rd_chk(input logic [6:0] ra, input logic [7:0] e);
      logic [7:0] v;
      host_u.read(ra, v);
      chk(v, e);
   endtask : rd_chk
   task automatic rd_all();
      rd_chk(7'h03, e3);
      rd_chk(7'h04, e4);
      rd_chk(7'h05, e5);
   endtask : rd_all
   // good write, with the expected image updated by writable bits
   task automatic wr_reg(input logic [6:0] wa, input logic [7:0] v);
      host_u.write(wa, v, 1'b0);
      if (wa == 7'h03) e3 = (e3 & 8'h08) | ({^v[6:0], v[6:0]} & 8'hf7);
      if (wa == 7'h04) e4 = (e4 & 8'h04) | (v & 8'hfb);
      if (wa == 7'h05 && !stop) e5 = v & 8'h20;
   endtask : wr_reg
   // main sequence
   initial
   begin
      {seed, err_total, checks, fails, cyc} = {32'h00002d1c, 128'h0};
      {rst_b_in, soft_rst, restart, fail_safe, stop, hl_we, hc_we} = 7'h00;
      {rs_lin, rs_can, hl, hc} = 8'h00;
      tick(6);
      rst_b_in = 1'b1;
      {e3, e4, e5} = 24'h142000;
      rd_all();
      rd_chk(7'h10, 8'h00);
      repeat (40)
      begin
         r = rnd();
         a = 7'h03 + 7'(r[9:8] % 2'd3);
         stop = r[10];
         wr_reg(a, r[7:0]);
         got = (a == 7'h03) ? e3 : (a == 7'h04) ? e4 : e5;
         rd_chk(a, got);
      end
      stop = 1'b0;
      chk(8'(fails), 8'h00);
      wr_reg(7'h03, 8'h45);
      host_u.write(7'h03, 8'h3a, 1'b1);
      tick(2);
      chk(8'(fails), 8'h01);
      rd_chk(7'h03, e3);
      chk(ms, 10'h1f4);
      wr_reg(7'h04, 8'hd9);
      tick(4);
      chk(opts, 3'h1);
      host_u.frame_end();
      tick(4);
      chk(opts, 3'h6);
      {hl_we, hl, hc_we, hc} = 6'h36;
      tick(1);
      {hl_we, hc_we} = 2'h0;
      e4 = {e4[7:5], 5'h12};
      rd_chk(7'h04, e4);
      wr_reg(7'h06, 8'hff);
      wr_reg(7'h07, 8'hf8);
      rd_chk(7'h06, 8'hc4);
      chk({hi, gi}, 2'h3);
      fail_safe = 1'b1;
      tick(1);
      fail_safe = 1'b0;
      e4 = (e4 & 8'he0) | 8'h09;
      rd_chk(7'h04, e4);
      rd_chk(7'h07, 8'ha7);
      wr_reg(7'h05, 8'hff);
      wr_reg(7'h03, 8'h7f);
      r = rnd();
      {rs_lin, rs_can, restart} = {r[3:0], 1'b1};
      tick(1);
      restart = 1'b0;
      e3 = (e3 & 8'hb0) | 8'h04;
      e4 = (e4 & 8'he0) | {3'h0, r[3:2], 1'b0, r[1:0]};
      rd_all();
      rd_chk(7'h06, 8'hc0);
      soft_rst = 1'b1;
      tick(1);
      soft_rst = 1'b0;
      {e3, e4, e5} = 24'h142000;
      rd_all();
      wr_reg(7'h05, 8'h20);
      rst_b_in = 1'b0;
      tick(6);
      rst_b_in = 1'b1;
      e5 = 8'h00;
      rd_all();
      report_and_stop();
   end
endmodule : wbc_regs_bench
`default_nettype wire

// ==== dv/wbc_regs_monitor.sv ====
// port assertions for the control register bank
`timescale 1ns/100ps
`default_nettype none
module wbc_regs_monitor
(
   input wire logic       clk_in,
   input wire logic       rst_b_in,
   input wire logic       chip_select_low_in,
   input wire logic       reg_wr_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       soft_reset_in,
   input wire logic       restart_in,
   input wire logic       fail_safe_entry_in,
   input wire logic       stop_mode_in,
   input wire logic       hw_lin_mode_we_in,
   input wire logic       hw_can_mode_we_in,
   input wire logic       spi_fail_out,
   input wire logic       stop_dog_disable_lo_out,
   input wire logic       dog_type_select_out,
   input wire logic       dog_start_on_bus_wake_out,
   input wire logic [2:0] dog_period_select_out,
   input wire logic       lin_flash_out,
   input wire logic       lin_low_slope_out,
   input wire logic       lin_transmit_timeout_en_out,
   input wire logic [1:0] lin_one_mode_out,
   input wire logic [1:0] can_mode_out,
   input wire logic       active_peak_threshold_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   logic       q;
   logic       wd_wr;
   logic [7:0] wd_q;
   // no reload pending; strobe aimed at the watchdog register
   assign q = !soft_reset_in && !restart_in;
   assign wd_wr = reg_wr_in && reg_addr_in == 7'h03;
   // write data one cycle late, for field comparisons
   always_ff @(posedge clk_in)
   begin
      wd_q <= reg_wdata_in;
   end
   a_bad_sum_flag: assert property (
      wd_wr && ^reg_wdata_in && q |=> spi_fail_out)
      else $error("odd checksum write without failure pulse");
   a_flag_cause: assert property (
      spi_fail_out |-> $past(wd_wr) && ^wd_q)
      else $error("failure pulse without odd checksum write");
   a_dog_fields: assert property (
      wd_wr && !(^reg_wdata_in) && q |=> {stop_dog_disable_lo_out,
      dog_type_select_out, dog_start_on_bus_wake_out,
      dog_period_select_out} == {wd_q[6:4], wd_q[2:0]})
      else $error("watchdog fields differ from write");
   a_peak_taken: assert property (
      reg_wr_in && reg_addr_in == 7'h05 && !stop_mode_in && q
      |=> active_peak_threshold_out == wd_q[5])
      else $error("peak bit not written");
   a_peak_locked: assert property (
      reg_wr_in && reg_addr_in == 7'h05 && stop_mode_in && q
      |=> $stable(active_peak_threshold_out))
      else $error("peak bit changed in stop mode");
   a_mode_write: assert property (
      reg_wr_in && reg_addr_in == 7'h04 && q && !fail_safe_entry_in &&
      !hw_lin_mode_we_in && !hw_can_mode_we_in
      |=> {lin_one_mode_out, can_mode_out} == {wd_q[4:3], wd_q[1:0]})
      else $error("mode fields differ from write");
   a_fail_wake: assert property (
      fail_safe_entry_in && q |=> {lin_one_mode_out, can_mode_out} == 4'h5)
      else $error("fail-safe did not force wake modes");
   a_opts_wait_cs: assert property (
      (!chip_select_low_in && q && !fail_safe_entry_in) [*4] |=> $stable(
      {lin_flash_out, lin_low_slope_out, lin_transmit_timeout_en_out}))
      else $error("lin options moved while selected");
   a_read_clean: assert property (
      $past(reg_addr_in) == 7'h05 |->
      reg_rdata_out == {2'h0, $past(active_peak_threshold_out), 5'h00})
      else $error("peak register read wrong");
   c_bad_sum: cover property (wd_wr && ^reg_wdata_in);
   c_stop_peak: cover property (reg_wr_in && reg_addr_in == 7'h05 &&
                                stop_mode_in);
   c_fail_safe: cover property (fail_safe_entry_in);
endmodule : wbc_regs_monitor
bind wbc_regs wbc_regs_monitor mon_u
(
   .clk_in, .rst_b_in, .chip_select_low_in, .reg_wr_in, .reg_addr_in,
   .reg_wdata_in, .reg_rdata_out, .soft_reset_in, .restart_in,
   .fail_safe_entry_in, .stop_mode_in, .hw_lin_mode_we_in,
   .hw_can_mode_we_in, .spi_fail_out, .stop_dog_disable_lo_out,
   .dog_type_select_out, .dog_start_on_bus_wake_out, .dog_period_select_out,
   .lin_flash_out, .lin_low_slope_out, .lin_transmit_timeout_en_out,
   .lin_one_mode_out, .can_mode_out, .active_peak_threshold_out
);
`default_nettype wire

// ==== pkg/wbc_pkg.sv ====
// constants for the watchdog and bus control register bank
package wbc_pkg;

   // ------------------------------------------------------------------
   // register addresses (7-bit)
   // ------------------------------------------------------------------
   localparam logic [6:0] ADDR_WATCHDOG_CONTROL   = 7'h03;
   localparam logic [6:0] ADDR_BUS_TRANSCEIVER    = 7'h04;
   localparam logic [6:0] ADDR_SUPPLY_PEAK        = 7'h05;
   localparam logic [6:0] ADDR_INT_WAKE_CONTROL   = 7'h06;
   localparam logic [6:0] ADDR_EXT_WAKE_CONTROL   = 7'h07;

   // ------------------------------------------------------------------
   // watchdog control fields
   // ------------------------------------------------------------------
   localparam int WD_CHECKSUM_BIT     = 7;
   localparam int WD_STOP_DISABLE_BIT = 6;
   localparam int WD_TYPE_BIT         = 5;
   localparam int WD_BUS_WAKE_BIT     = 4;
   localparam int WD_PERIOD_MSB       = 2;
   localparam logic [7:0] WD_RW_MASK      = 8'hf7;
   localparam logic [7:0] WD_RESET_VAL    = 8'h14;
   localparam logic [7:0] WD_RESTART_KEEP = 8'hb0;
   localparam logic [7:0] WD_RESTART_VAL  = 8'h04;

   // ------------------------------------------------------------------
   // bus transceiver control fields
   // ------------------------------------------------------------------
   localparam int BUS_FLASH_BIT    = 7;
   localparam int BUS_LOW_SLOPE    = 6;
   localparam int BUS_TX_TIMEOUT   = 5;
   localparam int BUS_LIN_MSB      = 4;
   localparam int BUS_LIN_LSB      = 3;
   localparam int BUS_CAN_MSB      = 1;
   localparam int BUS_CAN_LSB      = 0;
   localparam logic [7:0] BUS_RW_MASK       = 8'hfb;
   localparam logic [7:0] BUS_RESET_VAL     = 8'h20;
   localparam logic [7:0] BUS_RESTART_KEEP  = 8'he0;
   localparam logic [7:0] BUS_FAIL_KEEP     = 8'he0;
   localparam logic [7:0] BUS_FAIL_VAL      = 8'h09;

   // ------------------------------------------------------------------
   // supply peak control fields
   // ------------------------------------------------------------------
   localparam int PEAK_BIT = 5;
   localparam logic [7:0] PEAK_RW_MASK      = 8'h20;
   localparam logic [7:0] PEAK_RESET_VAL    = 8'h00;
   localparam logic [7:0] PEAK_RESTART_KEEP = 8'h20;

   // ------------------------------------------------------------------
   // internal and external wake control fields
   // ------------------------------------------------------------------
   localparam int IWK_STOP_DISABLE_BIT = 2;
   localparam logic [7:0] IWK_RW_MASK      = 8'hc4;
   localparam logic [7:0] IWK_RESET_VAL    = 8'h00;
   localparam logic [7:0] IWK_RESTART_KEEP = 8'hc0;
   localparam int EWK_GLOBAL_INT_BIT = 7;
   localparam logic [7:0] EWK_RW_MASK      = 8'ha7;
   localparam logic [7:0] EWK_RESET_VAL    = 8'h07;
   localparam logic [7:0] EWK_RESTART_KEEP = 8'ha7;
   localparam logic [7:0] EWK_FAIL_KEEP    = 8'ha0;
   localparam logic [7:0] EWK_FAIL_VAL     = 8'h07;

   // ------------------------------------------------------------------
   // watchdog period in ms per code
   // ------------------------------------------------------------------
   localparam logic [9:0] PERIOD_MS_0 = 10'h00a;
   localparam logic [9:0] PERIOD_MS_1 = 10'h014;
   localparam logic [9:0] PERIOD_MS_2 = 10'h032;
   localparam logic [9:0] PERIOD_MS_3 = 10'h064;
   localparam logic [9:0] PERIOD_MS_4 = 10'h0c8;
   localparam logic [9:0] PERIOD_MS_5 = 10'h1f4;
   localparam logic [9:0] PERIOD_MS_6 = 10'h3e8;

endpackage : wbc_pkg
